// ### taw_pins_model.sv
// Model of the external circuit on the timer input pins.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module taw_pins_model
   import taw_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic [TAW_CH-1:0] oe,
   output var logic [TAW_CH-1:0]  pin
);
   initial pin = 4'h0;
   // Pulses of hi cycles high, lo cycles low; a pin in output use
   // is never driven from outside
   task automatic pulses(input int ch, input int n, input int hi,
                         input int lo);
      repeat (n) begin
         pin[ch] = !oe[ch];
         repeat (hi) @(posedge mclk);
         #1 pin[ch] = 1'b0;
         repeat (lo) @(posedge mclk);
         #1;
      end
   endtask
endmodule
`default_nettype wire

// ### taw_pkg.sv
// Shared constants and types for the four-channel timer array.
// Assumes one system clock; all control arrives as plain ports.
package taw_pkg;

   localparam int          TAW_CH      = 4;
   localparam int          TAW_W       = 16;
   localparam int          TAW_PRE_W   = 15;
   localparam int          TAW_EXP_W   = 4;
   localparam logic [15:0] TAW_CNT_RST = 16'hffff;
   localparam logic [15:0] TAW_DAT_RST = 16'h0000;
   localparam logic [15:0] TAW_CAP_CLR = 16'h0000;
   localparam logic [15:0] TAW_ONE     = 16'h0001;
   localparam logic [7:0]  TAW_B_ZERO  = 8'h00;
   localparam logic [7:0]  TAW_B_ONE   = 8'h01;
   localparam logic [3:0]  TAW_SPLIT_CH = 4'ha;
   localparam int          TAW_DIV_CH  = 0;
   localparam int          TAW_LO_LSB  = 0;
   localparam int          TAW_HI_LSB  = 8;

   typedef enum logic [8:0] {
      TAW_M_INTERVAL = 9'h001,
      TAW_M_SQUARE   = 9'h002,
      TAW_M_EVENT    = 9'h004,
      TAW_M_DIVIDER  = 9'h008,
      TAW_M_PERIOD   = 9'h010,
      TAW_M_WIDTH    = 9'h020,
      TAW_M_DELAY    = 9'h040,
      TAW_M_ONESHOT  = 9'h080,
      TAW_M_PWM      = 9'h100
   } taw_mode_t;

   typedef enum logic [2:0] {
      TAW_ST_IDLE = 3'h1,
      TAW_ST_WAIT = 3'h2,
      TAW_ST_RUN  = 3'h4
   } taw_state_t;

endpackage

// ### taw_presc.sv
// Shared prescaler: free counter giving two selectable count ticks.
// Assumes the unit enable acts as a synchronous hold in reset.
`timescale 1ns/1ns
`default_nettype none
module taw_presc
   import taw_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   input  wire logic                 run,
   input  wire logic [TAW_EXP_W-1:0] sel0,
   input  wire logic [TAW_EXP_W-1:0] sel1,
   output logic                      tick0,
   output logic                      tick1
);

   logic [TAW_PRE_W-1:0] pre_ff;
   logic [TAW_PRE_W-1:0] nxt_pre;

   // High once every 2^exp cycles; exp 0 ticks every cycle
   function automatic logic taw_tick(input logic [TAW_PRE_W-1:0] cnt,
                                     input logic [TAW_EXP_W-1:0] exp);
      logic [TAW_PRE_W-1:0] m;
      m = TAW_PRE_W'((16'h0001 << exp) - 16'h0001);
      return (cnt & m) == m;
   endfunction

   assign nxt_pre = run ? pre_ff + TAW_PRE_W'(1) : '0;
   assign tick0   = run & taw_tick(pre_ff, sel0);
   assign tick1   = run & taw_tick(pre_ff, sel1);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= nxt_pre;
      end
   end

endmodule
`default_nettype wire

// ### taw_top.sv
// Four-channel 16-bit timer array with master/slave pairing and split.
// Assumes pins and controls are synchronous to mclk; start, stop and
// data writes are one-cycle strobes from the surrounding logic.
// Operation
// - Four 16-bit channels, each independent of other channels' modes.
// - Interval mode raises the channel interrupt at a fixed period.
// - Square-wave mode toggles the output pin on every interrupt.
// - Event mode counts input edges, interrupts when count is reached.
// - Only channel 0 divides its input clock onto its output pin.
// - Pulse-interval mode starts on an edge, captures on the next.
// - Width mode starts on one edge, captures on the opposite edge.
// - Delay mode starts on an input edge, interrupts after the delay.
// - A master sets the cycle; slaves run in step with it.
// - One-shot pair gives one pulse with set delay and width.
// - PWM pair: master gives period, slave gives duty.
// - One master and several slaves give PWM outputs sharing period.
// - Only channels 1 and 3 split into two 8-bit halves.
// - Upper half does interval only; other split modes use lower.
// - Compare use counts down from data, interrupts at zero.
// - Capture use copies the count into the data register.
// - Unit enable low holds the unit in reset, ignoring writes.
// - Count loads all ones on reset and when unit enable drops.
`timescale 1ns/1ns
`default_nettype none
module taw_top
   import taw_pkg::*;
(
   input  wire logic                          mclk,
   input  wire logic                          rst_b,
   input  wire logic                          unit_clock_enable,
   input  wire logic [TAW_EXP_W-1:0]          clk_exp0,
   input  wire logic [TAW_EXP_W-1:0]          clk_exp1,
   input  wire logic [TAW_CH-1:0]             ch_clk_sel,
   input  wire taw_mode_t [TAW_CH-1:0]        ch_mode,
   input  wire logic [TAW_CH-1:0]             ch_master,
   input  wire logic [TAW_CH-1:0]             ch_split,
   input  wire logic [TAW_CH-1:0]             ch_edge_fall,
   input  wire logic [TAW_CH-1:0]             ch_start,
   input  wire logic [TAW_CH-1:0]             ch_stop,
   input  wire logic [TAW_CH-1:0][1:0]        data_wr,
   input  wire logic [TAW_CH-1:0][TAW_W-1:0]  data_wdata,
   input  wire logic [TAW_CH-1:0]             timer_input_pin,
   output logic [TAW_CH-1:0]                  timer_output_pin,
   output logic [TAW_CH-1:0]                  timer_output_oe,
   output logic [TAW_CH-1:0]                  channel_interrupt,
   output logic [TAW_CH-1:0]                  channel_interrupt_hi,
   output logic [TAW_CH-1:0]                  ch_running,
   output logic [TAW_CH-1:0][TAW_W-1:0]       count_register,
   output logic [TAW_CH-1:0][TAW_W-1:0]       data_register
);

   logic                tick0;
   logic                tick1;
   logic [TAW_CH-1:0]   pin_prev_ff;
   logic [TAW_CH-1:0]   nxt_pin_prev;
   logic [TAW_CH-1:0]   rise;
   logic [TAW_CH-1:0]   fall;
   logic [TAW_CH-1:0]   mst_irq;

   // Interrupt of the nearest master strictly below a slave's index
   function automatic logic taw_master_irq(input logic [TAW_CH-1:0] mst,
                                           input logic [TAW_CH-1:0] irq,
                                           input int                idx);
      logic r;
      r = 1'b0;
      for (int j = 0; j < TAW_CH; j++) begin
         if (j < idx && mst[j]) begin
            r = irq[j];
         end
      end
      return r;
   endfunction

   taw_presc u_presc (
      .mclk  (mclk),
      .rst_b (rst_b),
      .run   (unit_clock_enable),
      .sel0  (clk_exp0),
      .sel1  (clk_exp1),
      .tick0 (tick0),
      .tick1 (tick1)
   );

   assign nxt_pin_prev = unit_clock_enable ? timer_input_pin : '0;
   assign rise = timer_input_pin & ~pin_prev_ff;
   assign fall = ~timer_input_pin & pin_prev_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_prev_ff <= '0;
      end else begin
         pin_prev_ff <= nxt_pin_prev;
      end
   end

   for (genvar i = 0; i < TAW_CH; i++) begin : g_ch
      taw_state_t      st_ff;
      taw_state_t      nxt_st;
      logic [15:0]     cnt_ff;
      logic [15:0]     nxt_cnt;
      logic [15:0]     dat_ff;
      logic [15:0]     nxt_dat;
      logic            out_ff;
      logic            nxt_out;
      logic            irq_ff;
      logic            nxt_irq;
      logic            irqh_ff;
      logic            nxt_irqh;

      // Each channel decodes only its own mode
      wire logic m_int = ch_mode[i] == TAW_M_INTERVAL;
      wire logic m_sq  = ch_mode[i] == TAW_M_SQUARE;
      wire logic m_ev  = ch_mode[i] == TAW_M_EVENT;
      wire logic m_div = (i == TAW_DIV_CH) &&
                         ch_mode[i] == TAW_M_DIVIDER;
      wire logic m_per = ch_mode[i] == TAW_M_PERIOD;
      wire logic m_wid = ch_mode[i] == TAW_M_WIDTH;
      wire logic m_dly = ch_mode[i] == TAW_M_DELAY;
      wire logic m_os  = ch_mode[i] == TAW_M_ONESHOT;
      wire logic m_pwm = ch_mode[i] == TAW_M_PWM;
      wire logic free  = m_int | m_sq | m_ev | m_div;
      wire logic cap   = m_per | m_wid;
      wire logic slave = m_os | m_pwm;
      wire logic split_on = TAW_SPLIT_CH[i] & ch_split[i];
      wire logic tick  = ch_clk_sel[i] ? tick1 : tick0;
      wire logic vedge = ch_edge_fall[i] ? fall[i] : rise[i];
      wire logic oedge = ch_edge_fall[i] ? rise[i] : fall[i];
      wire logic step  = (m_ev | m_div) ? vedge : tick;
      wire logic trig  = slave ? mst_irq[i] : vedge;
      wire logic zero  = split_on ? cnt_ff[7:0] == TAW_B_ZERO
                                  : cnt_ff == TAW_CAP_CLR;
      wire logic [15:0] dec = split_on ?
                    {cnt_ff[15:8], cnt_ff[7:0] - TAW_B_ONE} :
                    cnt_ff - TAW_ONE;
      wire logic [15:0] load = split_on ?
                    {cnt_ff[15:8], dat_ff[7:0]} : dat_ff;
      wire logic capt  = m_per ? vedge : oedge;
      wire logic up_zero = cnt_ff[15:8] == TAW_B_ZERO;

      assign mst_irq[i] = taw_master_irq(ch_master, channel_interrupt, i);

      always_comb begin
         nxt_st   = st_ff;
         nxt_cnt  = cnt_ff;
         nxt_dat  = dat_ff;
         nxt_out  = out_ff;
         nxt_irq  = 1'b0;
         nxt_irqh = 1'b0;
         if (data_wr[i][0]) begin
            nxt_dat[7:0] = data_wdata[i][7:0];
         end
         if (data_wr[i][1]) begin
            nxt_dat[15:8] = data_wdata[i][15:8];
         end
         case (st_ff)
            TAW_ST_IDLE: begin
               if (ch_start[i]) begin
                  if (free) begin
                     nxt_st  = TAW_ST_RUN;
                     nxt_cnt = dat_ff;
                  end else if (cap) begin
                     nxt_st  = TAW_ST_WAIT;
                     nxt_cnt = TAW_CAP_CLR;
                  end else if (m_dly | slave) begin
                     nxt_st  = TAW_ST_WAIT;
                     nxt_cnt = TAW_CNT_RST;
                  end
               end
            end
            TAW_ST_WAIT: begin
               if (trig) begin
                  nxt_st = TAW_ST_RUN;
                  if (cap) begin
                     nxt_cnt = TAW_CAP_CLR;
                  end else begin
                     nxt_cnt = dat_ff;
                     nxt_out = slave;
                  end
               end
            end
            TAW_ST_RUN: begin
               if (cap) begin
                  if (capt) begin
                     nxt_dat = cnt_ff;
                     nxt_cnt = TAW_CAP_CLR;
                     nxt_irq = 1'b1;
                     if (m_wid) begin
                        nxt_st = TAW_ST_WAIT;
                     end
                  end else if (tick) begin
                     nxt_cnt = cnt_ff + TAW_ONE;
                  end
               end else if (m_pwm && trig) begin
                  nxt_cnt = dat_ff;
                  nxt_out = 1'b1;
               end else if (step) begin
                  if (zero) begin
                     nxt_irq = 1'b1;
                     if (free) begin
                        nxt_cnt = load;
                        if (m_sq | m_div) begin
                           nxt_out = ~out_ff;
                        end
                     end else begin
                        nxt_cnt = TAW_CNT_RST;
                        nxt_st  = TAW_ST_WAIT;
                        nxt_out = 1'b0;
                     end
                  end else begin
                     nxt_cnt = dec;
                  end
               end
            end
            default: begin
               nxt_st = TAW_ST_IDLE;
            end
         endcase
         // Upper half of a split channel: 8-bit interval timer only
         if (split_on && st_ff == TAW_ST_RUN && tick) begin
            if (up_zero) begin
               nxt_cnt[15:8] = dat_ff[15:8];
               nxt_irqh      = 1'b1;
            end else begin
               nxt_cnt[15:8] = cnt_ff[15:8] - TAW_B_ONE;
            end
         end
         if (ch_stop[i]) begin
            nxt_st = TAW_ST_IDLE;
         end
         if (!unit_clock_enable) begin
            nxt_st   = TAW_ST_IDLE;
            nxt_cnt  = TAW_CNT_RST;
            nxt_dat  = TAW_DAT_RST;
            nxt_out  = 1'b0;
            nxt_irq  = 1'b0;
            nxt_irqh = 1'b0;
         end
      end

      always_ff @(posedge mclk or negedge rst_b) begin
         if (!rst_b) begin
            st_ff   <= TAW_ST_IDLE;
            cnt_ff  <= TAW_CNT_RST;
            dat_ff  <= TAW_DAT_RST;
            out_ff  <= 1'b0;
            irq_ff  <= 1'b0;
            irqh_ff <= 1'b0;
         end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            dat_ff  <= nxt_dat;
            out_ff  <= nxt_out;
            irq_ff  <= nxt_irq;
            irqh_ff <= nxt_irqh;
         end
      end

      // Drive the pin only in output modes so a shared pin stays an input
      assign timer_output_oe[i] = unit_clock_enable &
                                  (m_sq | m_div | slave);
      assign timer_output_pin[i]     = out_ff;
      assign channel_interrupt[i]    = irq_ff;
      assign channel_interrupt_hi[i] = irqh_ff;
      assign ch_running[i]           = st_ff != TAW_ST_IDLE;
      assign count_register[i]       = cnt_ff;
      assign data_register[i]        = dat_ff;
   end

endmodule
`default_nettype wire

// ### taw_top_bench.sv
// Self-checking bench for the timer array top.
// Assumes the pin model drives the timer input pins.
`timescale 1ns/1ns
`default_nettype none
module taw_top_bench;
   import taw_pkg::*;
   logic                         mclk = 1'b0;
   logic                         rst_b = 1'b0;
   logic                         unit_clock_enable = 1'b1;
   logic [TAW_EXP_W-1:0]         clk_exp0 = 4'h0;
   logic [TAW_EXP_W-1:0]         clk_exp1 = 4'h1;
   logic [TAW_CH-1:0]            ch_clk_sel = 4'h4;
   taw_mode_t [TAW_CH-1:0]       ch_mode;
   logic [TAW_CH-1:0]            ch_master = 4'h0;
   logic [TAW_CH-1:0]            ch_split = 4'h0;
   logic [TAW_CH-1:0]            ch_edge_fall = 4'h0;
   logic [TAW_CH-1:0]            ch_start = 4'h0;
   logic [TAW_CH-1:0]            ch_stop = 4'h0;
   logic [TAW_CH-1:0][1:0]       data_wr = 8'h00;
   logic [TAW_CH-1:0][TAW_W-1:0] data_wdata = 64'h0;
   wire logic [TAW_CH-1:0]       timer_input_pin;
   logic [TAW_CH-1:0]            timer_output_pin;
   logic [TAW_CH-1:0]            timer_output_oe;
   logic [TAW_CH-1:0]            channel_interrupt;
   logic [TAW_CH-1:0]            channel_interrupt_hi;
   logic [TAW_CH-1:0]            ch_running;
   logic [TAW_CH-1:0][TAW_W-1:0] count_register;
   logic [TAW_CH-1:0][TAW_W-1:0] data_register;
   int                           num_errors = 0;
   int                           checked = 0;
   int                           ev_n = 0;
   taw_top i_dut(.mclk, .rst_b, .unit_clock_enable, .clk_exp0, .clk_exp1,
      .ch_clk_sel, .ch_mode, .ch_master, .ch_split, .ch_edge_fall,
      .ch_start, .ch_stop, .data_wr, .data_wdata, .timer_input_pin,
      .timer_output_pin, .timer_output_oe, .channel_interrupt,
      .channel_interrupt_hi, .ch_running, .count_register, .data_register);
   taw_pins_model i_pins(.mclk, .oe(timer_output_oe),
      .pin(timer_input_pin));
   always #4 mclk = ~mclk;
   always @(posedge mclk) ev_n += channel_interrupt[1];
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic start(input int ch, input taw_mode_t m,
                        input logic [15:0] d);
      ch_mode[ch] = m;
      data_wdata[ch] = d;
      data_wr[ch] = 2'b11;
      tick(1);
      data_wr[ch] = 2'b00;
      ch_start[ch] = 1'b1;
      tick(1);
      ch_start[ch] = 1'b0;
   endtask
   task automatic stop(input int ch);
      ch_stop[ch] = 1'b1;
      tick(1);
      ch_stop[ch] = 1'b0;
   endtask
   task automatic wait_irq(input int ch, input bit hi, output int n);
      n = 0;
      while ((hi ? channel_interrupt_hi[ch] : channel_interrupt[ch])
             !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
   endtask
   // Cycles between two successive interrupts
   task automatic gap(input int ch, input bit hi, input int exp);
      int n;
      wait_irq(ch, hi, n);
      tick(1);
      wait_irq(ch, hi, n);
      chk("gap", 16'(exp), 16'(n + 1));
   endtask
   task automatic t_reset();
      for (int i = 0; i < TAW_CH; i++) begin
         chk("count", TAW_CNT_RST, count_register[i]);
         chk("data", TAW_DAT_RST, data_register[i]);
      end
      $display("test reset done");
   endtask
   task automatic t_interval();
      logic p;
      int   n;
      start(2, TAW_M_SQUARE, 16'h0002);
      start(0, TAW_M_INTERVAL, 16'h0002);
      gap(0, 0, 3);
      gap(2, 0, 6);
      p = timer_output_pin[2];
      tick(1);
      wait_irq(2, 0, n);
      chk("toggle", 16'(!p), 16'(timer_output_pin[2]));
      chk("oe", 16'h0001, 16'(timer_output_oe[2]));
      gap(0, 0, 3);
      chk("data", 16'h0002, data_register[0]);
      stop(0);
      stop(2);
      $display("test interval done");
   endtask
   task automatic t_event();
      start(1, TAW_M_EVENT, 16'h0002);
      ev_n = 0;
      i_pins.pulses(1, 2, 2, 2);
      tick(3);
      chk("events", 16'h0000, 16'(ev_n));
      i_pins.pulses(1, 1, 2, 2);
      tick(3);
      chk("events", 16'h0001, 16'(ev_n));
      stop(1);
      $display("test event done");
   endtask
   task automatic t_capture();
      ch_clk_sel = 4'h0;
      start(2, TAW_M_PERIOD, 16'h0000);
      i_pins.pulses(2, 2, 3, 7);
      tick(2);
      chk("interval", 16'h0009, data_register[2]);
      stop(2);
      start(2, TAW_M_WIDTH, 16'h0000);
      i_pins.pulses(2, 1, 5, 5);
      tick(2);
      chk("width", 16'h0004, data_register[2]);
      stop(2);
      $display("test capture done");
   endtask
   task automatic t_split();
      ch_split = 4'ha;
      start(3, TAW_M_INTERVAL, 16'h0201);
      gap(3, 1, 3);
      gap(3, 0, 2);
      stop(3);
      start(1, TAW_M_DIVIDER, 16'h0001);
      chk("run", 16'h0000, 16'(ch_running[1]));
      $display("test split done");
   endtask
   task automatic t_pwm();
      int hi [TAW_CH] = '{default: 0};
      ch_split = 4'h0;
      ch_master = 4'h1;
      start(1, TAW_M_PWM, 16'h0002);
      start(2, TAW_M_PWM, 16'h0000);
      start(3, TAW_M_PWM, 16'h0003);
      start(0, TAW_M_INTERVAL, 16'h0004);
      tick(12);
      repeat (5) begin
         for (int i = 1; i < TAW_CH; i++) begin
            hi[i] += timer_output_pin[i];
         end
         tick(1);
      end
      chk("duty1", 16'h0003, 16'(hi[1]));
      chk("duty2", 16'h0001, 16'(hi[2]));
      chk("duty3", 16'h0004, 16'(hi[3]));
      // Let the slaves finish their last pulse before stopping them
      stop(0);
      tick(8);
      ch_stop = 4'he;
      tick(1);
      ch_stop = 4'h0;
      $display("test pwm done");
   endtask
   task automatic t_delay();
      int n;
      int hi = 0;
      ch_master = 4'h1;
      start(1, TAW_M_ONESHOT, 16'h0001);
      start(0, TAW_M_DELAY, 16'h0002);
      i_pins.pulses(0, 1, 1, 1);
      wait_irq(0, 0, n);
      chk("delay", 16'h0002, 16'(n));
      repeat (8) begin
         hi += timer_output_pin[1];
         tick(1);
      end
      chk("shot", 16'h0002, 16'(hi));
      ch_stop = 4'h3;
      tick(1);
      ch_stop = 4'h0;
      ch_master = 4'h0;
      $display("test delay done");
   endtask
   task automatic t_enable();
      start(0, TAW_M_INTERVAL, 16'h0002);
      unit_clock_enable = 1'b0;
      data_wdata[0] = 16'h1234;
      data_wr[0] = 2'b11;
      ch_start[0] = 1'b1;
      tick(1);
      data_wr[0] = 2'b00;
      ch_start[0] = 1'b0;
      tick(1);
      chk("count", TAW_CNT_RST, count_register[0]);
      chk("data", TAW_DAT_RST, data_register[0]);
      chk("run", 16'h0000, 16'(ch_running));
      unit_clock_enable = 1'b1;
      tick(1);
      $display("test enable done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      foreach (ch_mode[i]) ch_mode[i] = TAW_M_INTERVAL;
      tick(3);
      rst_b = 1'b1;
      t_reset();
      t_interval();
      t_event();
      t_capture();
      t_split();
      t_pwm();
      t_delay();
      t_enable();
      results();
   end
   initial begin
      repeat (4000) @(posedge mclk);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire

// ### taw_top_sva.sv
// Port assertions for the timer array top.
// Assumes binding to taw_top; one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
module taw_top_sva
   import taw_pkg::*;
(
   input wire logic                          mclk,
   input wire logic                          rst_b,
   input wire logic                          unit_clock_enable,
   input wire taw_mode_t [TAW_CH-1:0]        ch_mode,
   input wire logic [TAW_CH-1:0]             ch_start,
   input wire logic [TAW_CH-1:0]             ch_stop,
   input wire logic [TAW_CH-1:0]             timer_output_pin,
   input wire logic [TAW_CH-1:0]             timer_output_oe,
   input wire logic [TAW_CH-1:0]             channel_interrupt,
   input wire logic [TAW_CH-1:0]             channel_interrupt_hi,
   input wire logic [TAW_CH-1:0]             ch_running,
   input wire logic [TAW_CH-1:0][TAW_W-1:0]  count_register,
   input wire logic [TAW_CH-1:0][TAW_W-1:0]  data_register
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   sequence s_go0;
      unit_clock_enable && ch_start[0] && !ch_stop[0] && !ch_running[0]
      && ch_mode[0] == TAW_M_INTERVAL;
   endsequence
   sequence s_off;
      timer_output_oe == 4'h0 ##1 channel_interrupt == 4'h0;
   endsequence
   property p_start;
      s_go0 |=> ch_running[0] && count_register[0] == data_register[0];
   endproperty
   property p_int;
      channel_interrupt[0] && ch_mode[0] == TAW_M_INTERVAL |->
      $past(count_register[0]) == 16'h0000
      && count_register[0] == data_register[0];
   endproperty
   property p_sq;
      ch_mode[2] == TAW_M_SQUARE && channel_interrupt[2] |->
      timer_output_pin[2] != $past(timer_output_pin[2]);
   endproperty
   property p_cap;
      ch_mode[2] == TAW_M_PERIOD && channel_interrupt[2] |->
      count_register[2] == TAW_CAP_CLR;
   endproperty
   property p_hold;
      !unit_clock_enable |=>
      count_register == {TAW_CH{TAW_CNT_RST}} && ch_running == 4'h0;
   endproperty
   property p_quiet;
      !unit_clock_enable |-> s_off;
   endproperty
   property p_half;
      (channel_interrupt_hi & ~TAW_SPLIT_CH) == 4'h0;
   endproperty
   property p_div;
      ch_mode[1] == TAW_M_DIVIDER && ch_start[1] |=> !ch_running[1];
   endproperty
   property p_stop;
      unit_clock_enable && ch_stop[0] |=>
      !ch_running[0] and
      (unit_clock_enable && !ch_start[0] |=> $stable(count_register[0]));
   endproperty
   a_start: assert property (p_start)
      else $error("start did not load the count");
   a_int: assert property (p_int)
      else $error("interrupt not tied to zero count and reload");
   a_sq: assert property (p_sq)
      else $error("square output did not toggle");
   a_cap: assert property (p_cap)
      else $error("count not cleared at capture");
   a_hold: assert property (p_hold)
      else $error("count not all ones while unit disabled");
   a_quiet: assert property (p_quiet)
      else $error("unit active while disabled");
   a_half: assert property (p_half)
      else $error("upper half interrupt on unsplittable channel");
   a_div: assert property (p_div)
      else $error("divider ran on channel one");
   a_stop: assert property (p_stop)
      else $error("stop did not halt and hold the count");
endmodule
bind taw_top taw_top_sva i_sva(.mclk, .rst_b, .unit_clock_enable, .ch_mode,
   .ch_start, .ch_stop, .timer_output_pin, .timer_output_oe,
   .channel_interrupt, .channel_interrupt_hi, .ch_running,
   .count_register, .data_register);
`default_nettype wire
